// ===== core/sil_consts.vh
/*
  Constants for the switch input interlock logic: register byte offsets,
  field positions, reset values and the interlock function codes.
  Assumes inclusion by sil_interlock.v and the test bench; holds definitions only.
*/
`ifndef SIL_CONSTS_VH
`define SIL_CONSTS_VH

// register byte offsets
`define SIL_OFF_CTRL 7'h00
`define SIL_OFF_POL 7'h04
`define SIL_OFF_DEB 7'h08
`define SIL_OFF_STAT 7'h0c
`define SIL_OFF_CNT 7'h10
`define SIL_OFF_ASG 7'h20
`define SIL_ASG_BANK 2'h1

// control register fields
`define SIL_CTRL_IND_AUTO 0
`define SIL_CTRL_HARDWIRED 1
`define SIL_CTRL_UV_EN 2
`define SIL_CTRL_DIR_B 3
`define SIL_CTRL_CNT_CLR 4
`define SIL_CTRL_W 4

// status register fields
`define SIL_ST_HLTH_LSB 0
`define SIL_ST_MODE_LSB 16
`define SIL_ST_ASG_ERR 18
`define SIL_ST_PLANT 19

// reset values
`define SIL_CTRL_RST 4'h0
`define SIL_POL_RST 10'h000
`define SIL_DEB_RST 16'h0004

// operating modes
`define SIL_MODE_MANUAL 2'h0
`define SIL_MODE_SERIAL 2'h1
`define SIL_MODE_HARD 2'h2

// interlock function codes
`define SIL_FN_UNUSED 5'h00
`define SIL_FN_PLANT 5'h01
`define SIL_FN_LOCKOUT 5'h02
`define SIL_FN_SP_ACCESS 5'h03
`define SIL_FN_AUTO_PERM 5'h04
`define SIL_FN_AUTO_A 5'h05
`define SIL_FN_AUTO_B 5'h06
`define SIL_FN_ESTOP_RST 5'h07
`define SIL_FN_UC_RST 5'h08
`define SIL_FN_TWO_WIRE 5'h09
`define SIL_FN_TEST 5'h0a
`define SIL_FN_REM_PERM 5'h0b
`define SIL_FN_COMM_SEL 5'h0c
`define SIL_FN_COUNTER 5'h0d
`define SIL_FN_AUX1_INH 5'h0e
`define SIL_FN_UV_INH 5'h0f
`define SIL_FN_MAIN_FB 5'h10
`define SIL_FN_STAR_FB 5'h11
`define SIL_FN_LAST 5'h11

`endif

// ===== core/sil_interlock.v
/*
  Switch input interlock logic: ten programmable switch inputs, each given
  one function, gate starts, trips, resets, keypad access, modes, relay
  inhibits, undervoltage restart and an event counter. Avalon-MM slave.
  Assumes all inputs synchronous to REF_CLK and one-cycle key pulses.
*/
//
// What this block does
// - plant interlock unhealthy raises trip, healthy clears
// - lockout reset clears overload, ground, stall only
// - setpoint access gates keypad setpoint changes
// - auto permissive healthy: auto starts, manual blocked
// - auto permissive unhealthy ignores auto start inputs
// - auto start B only for second direction starters
// - setting picks lamp for auto permissive operation
// - serial auto takes serial starts unless auto permissive healthy
// - hard-wired auto takes auto inputs when permitted
// - emergency stop reset clears emergency stop trip
// - undercurrent reset clears undercurrent trip
// - two-wire control: opened start means stop
// - test input suppresses counters except event counter
// - test healthy while running opens contactors
// - remote permissive splits switches and keypad
// - auto modes disable manual switches and keys
// - communication select forces serial, restores mode
// - event counter counts closures, wraps, clears
// - aux relay 1 inhibit keeps relay off
// - restart inhibit disables undervoltage restart
// - contact feedback routed to wye-delta starter
// - polarity setting defines healthy contact state
// - ten inputs, each function assigned once only
`timescale 1ns/1ps
`include "sil_consts.vh"

module sil_interlock #(
  parameter N_IN = 10,
  parameter DEB_W = 16
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire [6:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire [N_IN-1:0] SW_IN,
  input wire SW_START_A,
  input wire SW_START_B,
  input wire KEY_START_A,
  input wire KEY_START_B,
  input wire SER_START_A,
  input wire SER_START_B,
  input wire AUTO_KEY,
  input wire MANUAL_KEY,
  input wire SER_CNT_CLR,
  input wire MOTOR_RUNNING,
  input wire ESTOP_TRIP,
  input wire UC_TRIP,
  input wire AUX1_REQ,
  output reg PLANT_TRIP,
  output reg LOCKOUT_RESET,
  output reg ESTOP_RESET,
  output reg UC_RESET,
  output reg SETPOINT_KEY_OK,
  output reg START_A,
  output reg START_B,
  output reg STOP,
  output reg AUTO_LED,
  output reg MANUAL_LED,
  output reg STATS_INHIBIT,
  output reg AUX1_OUT,
  output reg UV_RESTART_EN,
  output reg MAIN_CONTACT_FB,
  output reg STAR_CONTACT_FB,
  output reg [15:0] EVENT_COUNT
);

  // is a function assigned to any input
  function fn_asg;
    input [5*N_IN-1:0] asg_v;
    input [4:0] code;
    integer k;
    begin
      fn_asg = 1'b0;
      for (k = 0; k < N_IN; k = k + 1) begin
        if (asg_v[5*k +: 5] == code) begin
          fn_asg = 1'b1;
        end
      end
    end
  endfunction

  // is a function assigned and its input healthy
  function fn_on;
    input [5*N_IN-1:0] asg_v;
    input [N_IN-1:0] hl;
    input [4:0] code;
    integer k;
    begin
      fn_on = 1'b0;
      for (k = 0; k < N_IN; k = k + 1) begin
        if (asg_v[5*k +: 5] == code && hl[k]) begin
          fn_on = 1'b1;
        end
      end
    end
  endfunction

  reg [`SIL_CTRL_W-1:0] ctrl;
  reg [N_IN-1:0] polarity;
  reg [DEB_W-1:0] deb_limit;
  reg [5*N_IN-1:0] asg;
  reg asg_err;
  reg ack;
  reg cnt_clr_req;
  reg [1:0] base_mode;
  wire [N_IN-1:0] healthy;
  reg prev_cnt_on;
  reg prev_test_on;
  reg prev_start;
  wire [N_IN-1:0] raw_healthy;
  wire acc;
  wire wr_hit;
  wire asg_sel;
  wire [3:0] asg_idx;
  wire [6:0] asg_off;

  // the window between request and ack is the single wait state
  assign acc = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = acc & ~ack;
  assign wr_hit = AVS_WRITE & ack;
  // assignment words run past one 32-byte bank, so decode by offset
  assign asg_off = AVS_ADDRESS - `SIL_OFF_ASG;
  assign asg_sel = (AVS_ADDRESS >= `SIL_OFF_ASG) && (asg_off[6:2] < N_IN)
    && (asg_off[1:0] == 2'h0);
  assign asg_idx = asg_off[5:2];

  // polarity flip: normally-closed inputs read healthy when open
  assign raw_healthy = SW_IN ^ polarity;

  // per-input debounce; a change acts only after deb_limit stable cycles
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_deb
      reg smp;
      reg hl;
      reg [DEB_W-1:0] cnt;
      assign healthy[gi] = hl;
      always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          smp <= 1'b0;
          cnt <= {DEB_W{1'b0}};
          hl <= 1'b0;
        end else begin
          smp <= raw_healthy[gi];
          if (smp == hl) begin
            cnt <= {DEB_W{1'b0}};
          end else if (cnt >= deb_limit) begin
            hl <= smp;
            cnt <= {DEB_W{1'b0}};
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
    end
  endgenerate

  // decoded function states
  wire plant_asg = fn_asg(asg, `SIL_FN_PLANT);
  wire plant_on = fn_on(asg, healthy, `SIL_FN_PLANT);
  wire lockout_on = fn_on(asg, healthy, `SIL_FN_LOCKOUT);
  wire sp_asg = fn_asg(asg, `SIL_FN_SP_ACCESS);
  wire sp_on = fn_on(asg, healthy, `SIL_FN_SP_ACCESS);
  wire ap_on = fn_on(asg, healthy, `SIL_FN_AUTO_PERM);
  wire auto_a_on = fn_on(asg, healthy, `SIL_FN_AUTO_A);
  wire auto_b_on = fn_on(asg, healthy, `SIL_FN_AUTO_B);
  wire estop_rst_on = fn_on(asg, healthy, `SIL_FN_ESTOP_RST);
  wire uc_rst_on = fn_on(asg, healthy, `SIL_FN_UC_RST);
  wire two_wire_on = fn_on(asg, healthy, `SIL_FN_TWO_WIRE);
  wire test_on = fn_on(asg, healthy, `SIL_FN_TEST);
  wire rp_asg = fn_asg(asg, `SIL_FN_REM_PERM);
  wire rp_on = fn_on(asg, healthy, `SIL_FN_REM_PERM);
  wire comm_on = fn_on(asg, healthy, `SIL_FN_COMM_SEL);
  wire cnt_on = fn_on(asg, healthy, `SIL_FN_COUNTER);
  wire aux1_inh_on = fn_on(asg, healthy, `SIL_FN_AUX1_INH);
  wire uv_inh_on = fn_on(asg, healthy, `SIL_FN_UV_INH);
  wire main_fb_on = fn_on(asg, healthy, `SIL_FN_MAIN_FB);
  wire star_fb_on = fn_on(asg, healthy, `SIL_FN_STAR_FB);

  // communication select overrides; the key mode is kept underneath
  wire [1:0] mode = comm_on ? `SIL_MODE_SERIAL : base_mode;

  // auto start inputs only count while auto permissive is healthy
  wire dir_b = ctrl[`SIL_CTRL_DIR_B];
  wire auto_a = ap_on & auto_a_on;
  wire auto_b = ap_on & auto_b_on & dir_b;

  // start source selection per mode
  reg next_start_a;
  reg next_start_b;
  always @* begin
    next_start_a = 1'b0;
    next_start_b = 1'b0;
    case (mode)
      `SIL_MODE_MANUAL: begin
        if (ap_on) begin
          next_start_a = auto_a;
          next_start_b = auto_b;
        end else if (rp_asg) begin
          next_start_a = rp_on ? SW_START_A : KEY_START_A;
          next_start_b = rp_on ? SW_START_B : KEY_START_B;
        end else begin
          next_start_a = SW_START_A | KEY_START_A;
          next_start_b = SW_START_B | KEY_START_B;
        end
      end
      `SIL_MODE_SERIAL: begin
        // manual switches and keys play no part here
        if (ap_on) begin
          next_start_a = auto_a;
          next_start_b = auto_b;
        end else begin
          next_start_a = SER_START_A;
          next_start_b = SER_START_B;
        end
      end
      `SIL_MODE_HARD: begin
        next_start_a = auto_a;
        next_start_b = auto_b;
      end
      default: begin
        next_start_a = 1'b0;
        next_start_b = 1'b0;
      end
    endcase
  end

  wire start_lvl = next_start_a | next_start_b;

  // interlock outputs, all registered
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PLANT_TRIP <= 1'b0;
      LOCKOUT_RESET <= 1'b0;
      ESTOP_RESET <= 1'b0;
      UC_RESET <= 1'b0;
      SETPOINT_KEY_OK <= 1'b0;
      START_A <= 1'b0;
      START_B <= 1'b0;
      STOP <= 1'b0;
      AUTO_LED <= 1'b0;
      MANUAL_LED <= 1'b0;
      STATS_INHIBIT <= 1'b0;
      AUX1_OUT <= 1'b0;
      UV_RESTART_EN <= 1'b0;
      MAIN_CONTACT_FB <= 1'b0;
      STAR_CONTACT_FB <= 1'b0;
      prev_start <= 1'b0;
      prev_test_on <= 1'b0;
    end else begin
      PLANT_TRIP <= plant_asg & ~plant_on;
      LOCKOUT_RESET <= lockout_on;
      ESTOP_RESET <= estop_rst_on & ESTOP_TRIP;
      UC_RESET <= uc_rst_on & UC_TRIP;
      SETPOINT_KEY_OK <= ~sp_asg | sp_on;
      START_A <= next_start_a;
      START_B <= next_start_b;
      prev_start <= start_lvl;
      prev_test_on <= test_on;
      // dropping start under two-wire, or test going healthy while running
      STOP <= (two_wire_on & prev_start & ~start_lvl)
        | (test_on & ~prev_test_on & MOTOR_RUNNING);
      if (mode == `SIL_MODE_MANUAL && ap_on) begin
        AUTO_LED <= ctrl[`SIL_CTRL_IND_AUTO];
        MANUAL_LED <= ~ctrl[`SIL_CTRL_IND_AUTO];
      end else begin
        AUTO_LED <= (mode != `SIL_MODE_MANUAL);
        MANUAL_LED <= (mode == `SIL_MODE_MANUAL);
      end
      STATS_INHIBIT <= test_on;
      AUX1_OUT <= AUX1_REQ & ~aux1_inh_on;
      UV_RESTART_EN <= ctrl[`SIL_CTRL_UV_EN] & ~uv_inh_on;
      MAIN_CONTACT_FB <= main_fb_on;
      STAR_CONTACT_FB <= star_fb_on;
    end
  end

  // key-selected mode; keys have no effect under communication select
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      base_mode <= `SIL_MODE_MANUAL;
    end else if (!comm_on) begin
      if (AUTO_KEY) begin
        base_mode <= ctrl[`SIL_CTRL_HARDWIRED] ? `SIL_MODE_HARD : `SIL_MODE_SERIAL;
      end else if (MANUAL_KEY) begin
        base_mode <= `SIL_MODE_MANUAL;
      end
    end
  end

  // event counter: a closure in the clear cycle still counts as one
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      EVENT_COUNT <= 16'h0000;
      prev_cnt_on <= 1'b0;
    end else begin
      prev_cnt_on <= cnt_on;
      if (cnt_on && !prev_cnt_on) begin
        if (cnt_clr_req || SER_CNT_CLR) begin
          EVENT_COUNT <= 16'h0001;
        end else begin
          EVENT_COUNT <= EVENT_COUNT + 16'h0001;
        end
      end else if (cnt_clr_req || SER_CNT_CLR) begin
        EVENT_COUNT <= 16'h0000;
      end
    end
  end

  // is the requested code free for input idx
  reg code_free;
  integer j;
  always @* begin
    code_free = 1'b1;
    for (j = 0; j < N_IN; j = j + 1) begin
      if (j != asg_idx && asg[5*j +: 5] == AVS_WRITEDATA[4:0]
          && AVS_WRITEDATA[4:0] != `SIL_FN_UNUSED) begin
        code_free = 1'b0;
      end
    end
  end

  // register writes take effect at the edge where waitrequest is low
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack <= 1'b0;
      ctrl <= `SIL_CTRL_RST;
      polarity <= `SIL_POL_RST;
      deb_limit <= `SIL_DEB_RST;
      asg <= {5*N_IN{1'b0}};
      asg_err <= 1'b0;
      cnt_clr_req <= 1'b0;
    end else begin
      ack <= acc & ~ack;
      cnt_clr_req <= 1'b0;
      if (wr_hit) begin
        if (AVS_ADDRESS == `SIL_OFF_CTRL) begin
          ctrl <= AVS_WRITEDATA[`SIL_CTRL_W-1:0];
          cnt_clr_req <= AVS_WRITEDATA[`SIL_CTRL_CNT_CLR];
        end else if (AVS_ADDRESS == `SIL_OFF_POL) begin
          polarity <= AVS_WRITEDATA[N_IN-1:0];
        end else if (AVS_ADDRESS == `SIL_OFF_DEB) begin
          deb_limit <= AVS_WRITEDATA[DEB_W-1:0];
        end else if (asg_sel) begin
          // duplicates and unknown codes are refused, old value kept
          if (code_free && AVS_WRITEDATA[4:0] <= `SIL_FN_LAST) begin
            asg[5*asg_idx +: 5] <= AVS_WRITEDATA[4:0];
            asg_err <= 1'b0;
          end else begin
            asg_err <= 1'b1;
          end
        end
      end
    end
  end

  // read data registered on the first edge, held through the ack edge
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ && !ack) begin
      AVS_READDATA <= 32'h00000000;
      if (AVS_ADDRESS == `SIL_OFF_CTRL) begin
        AVS_READDATA[`SIL_CTRL_W-1:0] <= ctrl;
      end else if (AVS_ADDRESS == `SIL_OFF_POL) begin
        AVS_READDATA[N_IN-1:0] <= polarity;
      end else if (AVS_ADDRESS == `SIL_OFF_DEB) begin
        AVS_READDATA[DEB_W-1:0] <= deb_limit;
      end else if (AVS_ADDRESS == `SIL_OFF_STAT) begin
        AVS_READDATA[`SIL_ST_HLTH_LSB +: N_IN] <= healthy;
        AVS_READDATA[`SIL_ST_MODE_LSB +: 2] <= mode;
        AVS_READDATA[`SIL_ST_ASG_ERR] <= asg_err;
        AVS_READDATA[`SIL_ST_PLANT] <= PLANT_TRIP;
      end else if (AVS_ADDRESS == `SIL_OFF_CNT) begin
        AVS_READDATA[15:0] <= EVENT_COUNT;
      end else if (asg_sel) begin
        AVS_READDATA[4:0] <= asg[5*asg_idx +: 5];
      end
    end
  end

endmodule

// ===== testbench/sil_interlock_assertions.sv
/* port checker for sil_interlock: bus wait state, resets, stop, lamps, counter.
   assumes a bind from the bench top and the design's REF_CLK and RSTN. */
`timescale 1ns/1ps
module sil_interlock_assertions (
  input wire REF_CLK,
  input wire RSTN,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire AVS_WAITREQUEST,
  input wire MOTOR_RUNNING,
  input wire ESTOP_TRIP,
  input wire UC_TRIP,
  input wire AUX1_REQ,
  input wire ESTOP_RESET,
  input wire UC_RESET,
  input wire STOP,
  input wire AUTO_LED,
  input wire MANUAL_LED,
  input wire STATS_INHIBIT,
  input wire AUX1_OUT,
  input wire [15:0] EVENT_COUNT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // exactly one wait state, so a stuck ack shows at once
  a_bus_one_wait: assert property ($rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("bus wait state count wrong");
  a_stop_one_cycle: assert property (STOP |=> !STOP)
    else $error("stop longer than one cycle");
  a_estop_reset_cause: assert property (ESTOP_RESET |-> $past(ESTOP_TRIP))
    else $error("estop reset without trip");
  a_uc_reset_cause: assert property (UC_RESET |-> $past(UC_TRIP))
    else $error("undercurrent reset without trip");
  a_aux1_cause: assert property (AUX1_OUT |-> $past(AUX1_REQ))
    else $error("aux relay on without request");
  a_test_opens: assert property ($rose(STATS_INHIBIT) && $past(MOTOR_RUNNING) |-> STOP)
    else $error("test while running did not stop");
  a_lamp_one_lit: assert property ($past(RSTN) |-> AUTO_LED ^ MANUAL_LED)
    else $error("mode lamps not exactly one");
  // allows a step of one or a drop to zero, which covers the wrap too
  a_count_step: assert property ($changed(EVENT_COUNT) |->
    EVENT_COUNT == $past(EVENT_COUNT) + 16'h1 || EVENT_COUNT == 16'h0)
    else $error("event counter jumped");
endmodule

// ===== testbench/sil_field.sv
/* field side model: switch contacts and the motor contactor.
   assumes the bench asks for contact states; contacts dwell HOLD cycles. */
`timescale 1ns/1ps
module sil_field #(
  parameter HOLD = 4
) (
  input wire clk,
  input wire rstn,
  input wire [9:0] want,
  input wire start_a,
  input wire start_b,
  input wire stop,
  output reg [9:0] sw,
  output reg running
);
  reg [7:0] dwell;
  // a contact moves only after dwelling, so no pulse is shorter than HOLD
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw <= 10'h000;
      dwell <= 8'h00;
    end else if (want != sw && dwell >= HOLD) begin
      sw <= want;
      dwell <= 8'h00;
    end else if (dwell != 8'hff) begin
      dwell <= dwell + 8'h01;
    end
  end
  // contactor pulls in on a start and drops on stop; stop wins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) running <= 1'b0;
    else if (stop) running <= 1'b0;
    else if (start_a || start_b) running <= 1'b1;
  end
endmodule

// ===== testbench/sil_interlock_test.sv
/* self-checking bench for sil_interlock with field model and checker.
   assumes sil_consts.vh on the include path and a 200 MHz clock. */
`timescale 1ns/1ps
`include "sil_consts.vh"
`define CK(n, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
  err_total = err_total + 1; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module sil_interlock_test;
  reg clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, stop_seen = 1'b0;
  reg [6:0] addr = 7'h00;
  reg [31:0] wdata = 32'h0, q;
  reg [9:0] want = 10'h000, pol;
  reg swsa = 1'b0, swsb = 1'b0, ksa = 1'b0, ksb = 1'b0, ssa = 1'b0, ssb = 1'b0;
  reg akey = 1'b0, mkey = 1'b0, sclr = 1'b0, estop = 1'b0, uct = 1'b0, auxr = 1'b0;
  integer err_total = 0, total_checks = 0, seed, i, n;
  wire [31:0] rdata;
  wire [15:0] cnt;
  wire [9:0] sw;
  wire waitr, plant, lrst, erst, urst, spok, sta, stb, stop, aled, mled, sinh, aux1, uven;
  wire mfb, sfb, run;
  always #2.5 clk = ~clk;
  // sticky record of any stop pulse
  always @(posedge clk) if (stop) stop_seen <= 1'b1;
  sil_interlock dut (.REF_CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitr),
    .SW_IN(sw), .SW_START_A(swsa), .SW_START_B(swsb), .KEY_START_A(ksa), .KEY_START_B(ksb),
    .SER_START_A(ssa), .SER_START_B(ssb), .AUTO_KEY(akey), .MANUAL_KEY(mkey),
    .SER_CNT_CLR(sclr), .MOTOR_RUNNING(run), .ESTOP_TRIP(estop), .UC_TRIP(uct),
    .AUX1_REQ(auxr), .PLANT_TRIP(plant), .LOCKOUT_RESET(lrst), .ESTOP_RESET(erst),
    .UC_RESET(urst), .SETPOINT_KEY_OK(spok), .START_A(sta), .START_B(stb), .STOP(stop),
    .AUTO_LED(aled), .MANUAL_LED(mled), .STATS_INHIBIT(sinh), .AUX1_OUT(aux1),
    .UV_RESTART_EN(uven), .MAIN_CONTACT_FB(mfb), .STAR_CONTACT_FB(sfb), .EVENT_COUNT(cnt));
  sil_field fld (.clk(clk), .rstn(rstn), .want(want), .start_a(sta), .start_b(stb),
    .stop(stop), .sw(sw), .running(run));
  // healthy state from contact and polarity, normally closed flips it
  function [9:0] hlth(input [9:0] c, input [9:0] p);
    hlth = c ^ p;
  endfunction
  task w(input integer k);
    repeat (k) @(posedge clk);
  endtask
  // one bus transfer: hold until waitrequest is seen low at a rising edge
  task bus(input wrt, input [6:0] a, input [31:0] d);
    integer k;
    begin
      k = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= wrt;
      rd <= !wrt;
      @(posedge clk);
      while (waitr !== 1'b0 && k < 64) begin
        @(posedge clk);
        k = k + 1;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 64) begin
        err_total = err_total + 1;
        give_verdict;
      end
    end
  endtask
  task set(input [9:0] v);
    begin
      @(posedge clk);
      want <= v;
      w(24);
    end
  endtask
  task key(input au);
    begin
      @(posedge clk);
      akey <= au;
      mkey <= !au;
      @(posedge clk);
      akey <= 1'b0;
      mkey <= 1'b0;
      w(3);
      bus(0, `SIL_OFF_STAT, 0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // watchdog well past the expected thousand or so cycles
  initial begin
    #300000;
    err_total = err_total + 1;
    give_verdict;
  end
  initial begin
    seed = 95728;
    w(16);
    rstn <= 1'b1;
    w(2);
    `CK("keyok", 1'b1, spok)
    bus(0, `SIL_OFF_DEB, 0);
    `CK("deb", {16'h0, `SIL_DEB_RST}, q)
    bus(1, 7'h48, $random(seed));
    bus(0, 7'h48, 0);
    `CK("unmapped", 32'h0, q)
    bus(1, `SIL_OFF_DEB, 32'h2);
    for (i = 0; i < 10; i = i + 1) bus(1, `SIL_OFF_ASG + 4 * i, i + 1);
    bus(1, `SIL_OFF_ASG + 4, 1);
    bus(0, `SIL_OFF_STAT, 0);
    `CK("asgerr", 1'b1, q[`SIL_ST_ASG_ERR])
    bus(0, `SIL_OFF_ASG + 4, 0);
    `CK("asg", 32'h2, q)
    $display("test registers done");
    // random contacts under random polarity
    for (i = 0; i < 3; i = i + 1) begin
      pol = $random(seed);
      bus(1, `SIL_OFF_POL, {22'h0, pol});
      set($random(seed));
      bus(0, `SIL_OFF_STAT, 0);
      `CK("healthy", hlth(want, pol), q[9:0])
    end
    bus(1, `SIL_OFF_POL, 0);
    set(10'h000);
    `CK("plant", 1'b1, plant)
    `CK("keyok", 1'b0, spok)
    estop <= 1'b1;
    uct <= 1'b1;
    set(10'h0c7);
    `CK("plant", 1'b0, plant)
    `CK("lockrst", 1'b1, lrst)
    `CK("keyok", 1'b1, spok)
    `CK("estoprst", 1'b1, erst)
    `CK("ucrst", 1'b1, urst)
    set(10'h010);
    `CK("starta", 1'b0, sta)
    swsa <= 1'b1;
    ksa <= 1'b1;
    set(10'h008);
    `CK("starta", 1'b0, sta)
    set(10'h038);
    `CK("starta", 1'b1, sta)
    for (i = 0; i < 2; i = i + 1) begin
      bus(1, `SIL_OFF_CTRL, (1 << `SIL_CTRL_DIR_B) | i);
      w(3);
      `CK("startb", 1'b1, stb)
      `CK("autoled", i[0], aled)
      `CK("manled", !i[0], mled)
    end
    bus(1, `SIL_OFF_CTRL, 0);
    w(3);
    `CK("startb", 1'b0, stb)
    stop_seen <= 1'b0;
    set(10'h238);
    `CK("stop", 1'b1, stop_seen)
    `CK("statinh", 1'b1, sinh)
    swsa <= 1'b0;
    ksa <= 1'b0;
    $display("test start gating done");
    // open all contacts first so a new counter input starts unhealthy
    set(10'h000);
    for (i = 0; i < 10; i = i + 1) bus(1, `SIL_OFF_ASG + 4 * i, 0);
    for (i = 0; i < 8; i = i + 1) bus(1, `SIL_OFF_ASG + 4 * i, i == 0 ? 9 : i + 10);
    set(10'h000);
    n = 2 + ($random(seed) & 3);
    for (i = 0; i < n; i = i + 1) begin
      set(10'h008);
      set(10'h000);
    end
    `CK("count", n[15:0], cnt)
    bus(0, `SIL_OFF_CNT, 0);
    `CK("countreg", n, q)
    bus(1, `SIL_OFF_CTRL, 1 << `SIL_CTRL_CNT_CLR);
    w(3);
    `CK("count", 16'h0, cnt)
    set(10'h008);
    sclr <= 1'b1;
    w(1);
    sclr <= 1'b0;
    w(3);
    `CK("count", 16'h0, cnt)
    auxr <= 1'b1;
    set(10'h000);
    `CK("aux1", 1'b1, aux1)
    set(10'h010);
    `CK("aux1", 1'b0, aux1)
    bus(1, `SIL_OFF_CTRL, 1 << `SIL_CTRL_UV_EN);
    set(10'h000);
    `CK("uvrest", 1'b1, uven)
    set(10'h020);
    `CK("uvrest", 1'b0, uven)
    set(10'h0c0);
    `CK("mainfb", 1'b1, mfb)
    `CK("starfb", 1'b1, sfb)
    set(10'h002);
    swsa <= 1'b1;
    w(3);
    `CK("starta", 1'b1, sta)
    set(10'h000);
    `CK("starta", 1'b0, sta)
    swsa <= 1'b0;
    set(10'h001);
    ksa <= 1'b1;
    w(3);
    `CK("running", 1'b1, run)
    stop_seen <= 1'b0;
    ksa <= 1'b0;
    w(3);
    `CK("stop", 1'b1, stop_seen)
    $display("test functions done");
    bus(1, `SIL_OFF_CTRL, 1 << `SIL_CTRL_HARDWIRED);
    key(1'b1);
    `CK("mode", `SIL_MODE_HARD, q[17:16])
    ksa <= 1'b1;
    set(10'h004);
    `CK("starta", 1'b0, sta)
    bus(0, `SIL_OFF_STAT, 0);
    `CK("mode", `SIL_MODE_SERIAL, q[17:16])
    ksa <= 1'b0;
    ssa <= 1'b1;
    w(3);
    `CK("starta", 1'b1, sta)
    ssa <= 1'b0;
    set(10'h000);
    bus(0, `SIL_OFF_STAT, 0);
    `CK("mode", `SIL_MODE_HARD, q[17:16])
    key(1'b0);
    bus(1, `SIL_OFF_CTRL, 0);
    key(1'b1);
    `CK("mode", `SIL_MODE_SERIAL, q[17:16])
    $display("test modes done");
    give_verdict;
  end
endmodule
bind sil_interlock sil_interlock_assertions chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MOTOR_RUNNING(MOTOR_RUNNING), .ESTOP_TRIP(ESTOP_TRIP), .UC_TRIP(UC_TRIP),
  .AUX1_REQ(AUX1_REQ), .ESTOP_RESET(ESTOP_RESET), .UC_RESET(UC_RESET), .STOP(STOP),
  .AUTO_LED(AUTO_LED), .MANUAL_LED(MANUAL_LED), .STATS_INHIBIT(STATS_INHIBIT),
  .AUX1_OUT(AUX1_OUT), .EVENT_COUNT(EVENT_COUNT));
